// ---- design/cap_params.svh ----
// Overview of operation
// - slave port: 16-bit address, 32-bit data
// - variable-latency reads, valid marks data
// - stall while busy; master holds request
// - stall drops with read-data-valid
// - fixed timeout counter flags missing data
// - one clock, synchronous reset to idle
`ifndef CAP_PARAMS_SVH
`define CAP_PARAMS_SVH

`define CAP_ADDR_W        16
`define CAP_DATA_W        32
`define CAP_CLK_MHZ       10
`define CAP_TIMEOUT_NS    12800
`define CAP_TIMEOUT_CYC   ((`CAP_TIMEOUT_NS * `CAP_CLK_MHZ) / 1000)
`define CAP_CNT_W         8
`define CAP_READDATA_RST  32'h0000_0000
`define CAP_TIMEOUT_DATA  32'hdead_beef

`endif

// ---- design/cap_pkg.sv ----
`default_nettype none
package cap_pkg;
  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_RD_WAIT,
    CAP_WR_WAIT
  } cap_state_t;
endpackage
`default_nettype wire

// ---- design/cap_timer.sv ----
`include "cap_params.svh"
`default_nettype none
module cap_timer
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic sync_clr,
  // control
  input  wire logic run,
  output logic      expired
);
  typedef struct packed {
    logic [`CAP_CNT_W-1:0] cnt;
  } cap_tmr_t;

  cap_tmr_t st_r;
  cap_tmr_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (sync_clr || !run)
      st_nxt.cnt = '0;
    else if (!expired)
      st_nxt.cnt = st_r.cnt + `CAP_CNT_W'(1);
  end

  // fixed count, never reprogrammed
  assign expired = run && (st_r.cnt == `CAP_CNT_W'(`CAP_TIMEOUT_CYC - 1));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule // cap_timer
`default_nettype wire

// ---- design/cap_csr_port.sv ----
`include "cap_params.svh"
`default_nettype none
module cap_csr_port
(
  // clock and resets
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   sync_reset,
  // bus master side
  input  wire logic [`CAP_ADDR_W-1:0] status_addr,
  input  wire logic                   status_read,
  input  wire logic                   status_write,
  input  wire logic [`CAP_DATA_W-1:0] status_writedata,
  output logic [`CAP_DATA_W-1:0]      status_readdata,
  output logic                        status_readdata_valid,
  output logic                        status_waitrequest,
  output logic                        status_read_timeout,
  // register fabric side
  output logic [`CAP_ADDR_W-1:0]      reg_addr,
  output logic                        reg_rd,
  output logic                        reg_wr,
  output logic [`CAP_DATA_W-1:0]      reg_wdata,
  input  wire logic [`CAP_DATA_W-1:0] reg_rdata,
  input  wire logic                   reg_ack
);
  typedef struct packed {
    cap_pkg::cap_state_t    state;
    logic [`CAP_DATA_W-1:0] rdata;
    logic                   rvalid;
    logic                   tout;
    // closing cycle of an access; the request still seen then is not new
    logic                   done;
  } cap_port_t;

  cap_port_t st_r;
  cap_port_t st_nxt;
  logic      expired;
  logic      busy;

  ////////////////////////////////////////////////////////////////////////////
  // request decode, shared by fabric strobes, stall and the state machine

  // read accepted only when idle and not in the closing cycle
  function automatic logic rd_take
  (
    input logic idle,
    input logic done,
    input logic rd
  );
    rd_take = idle && !done && rd;
  endfunction

  // write accepted under the same terms; a read wins a tie
  function automatic logic wr_take
  (
    input logic idle,
    input logic done,
    input logic rd,
    input logic wr
  );
    wr_take = idle && !done && wr && !rd;
  endfunction

  // any command on the bus
  function automatic logic req_any
  (
    input logic rd,
    input logic wr
  );
    req_any = rd || wr;
  endfunction

  // stall: busy, or a fresh command that has not been answered yet
  function automatic logic stall_level
  (
    input logic busy_now,
    input logic done,
    input logic rd,
    input logic wr
  );
    stall_level = busy_now || (req_any(rd, wr) && !done);
  endfunction

  // read answer: data, valid pulse and, on timeout, the flag
  function automatic cap_port_t answer_rd
  (
    input cap_port_t              s,
    input logic [`CAP_DATA_W-1:0] data,
    input logic                   tmo
  );
    answer_rd        = s;
    answer_rd.state  = cap_pkg::CAP_IDLE;
    answer_rd.rdata  = data;
    answer_rd.rvalid = 1'b1;
    answer_rd.tout   = tmo;
    answer_rd.done   = 1'b1;
  endfunction

  // write answer: no data, no valid, stall drops next cycle
  function automatic cap_port_t close_wr
  (
    input cap_port_t s
  );
    close_wr       = s;
    close_wr.state = cap_pkg::CAP_IDLE;
    close_wr.done  = 1'b1;
  endfunction

  // idle state as left by a reset
  function automatic cap_port_t idle_clear();
    idle_clear        = '0;
    idle_clear.state  = cap_pkg::CAP_IDLE;
    idle_clear.rdata  = `CAP_READDATA_RST;
    idle_clear.rvalid = 1'b0;
    idle_clear.tout   = 1'b0;
    idle_clear.done   = 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  cap_timer u_timer
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .sync_clr (sync_reset),
    .run      (busy),
    .expired  (expired)
  );

  assign busy = (st_r.state != cap_pkg::CAP_IDLE);

  // pass request straight to fabric; master holds it steady while stalled
  assign reg_addr  = status_addr;
  assign reg_wdata = status_writedata;
  assign reg_rd    = (st_r.state == cap_pkg::CAP_RD_WAIT)
                     || rd_take(!busy, st_r.done, status_read);
  assign reg_wr    = (st_r.state == cap_pkg::CAP_WR_WAIT)
                     || wr_take(!busy, st_r.done, status_read, status_write);

  ////////////////////////////////////////////////////////////////////////////
  // transfer timeline, one access at a time:
  //   c0     command seen while idle: taken, stall high, fabric strobe high
  //   c1..   waiting on the fabric acknowledge or the timer
  //   ack    answer registered at this edge
  //   next   closing cycle: stall low, valid pulse for a read, done high
  // the master still holds its command in the closing cycle, so done
  // keeps that same command from being taken a second time.
  // a read that never gets an acknowledge is closed by the timer with
  // filler data and the timeout flag, so the master is never left stalled.
  // a write that times out closes quietly, with no flag.
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.tout   = 1'b0;
    st_nxt.done   = 1'b0;
    unique case (st_r.state)
      cap_pkg::CAP_IDLE:
      begin
        if (rd_take(1'b1, st_r.done, status_read))
          st_nxt.state = cap_pkg::CAP_RD_WAIT;
        else if (wr_take(1'b1, st_r.done, status_read, status_write))
          st_nxt.state = cap_pkg::CAP_WR_WAIT;
      end
      cap_pkg::CAP_RD_WAIT:
      begin
        if (reg_ack)
          st_nxt = answer_rd(st_r, reg_rdata, 1'b0);
        else if (expired)
          st_nxt = answer_rd(st_r, `CAP_TIMEOUT_DATA, 1'b1);
      end
      cap_pkg::CAP_WR_WAIT:
      begin
        if (reg_ack || expired)
          st_nxt = close_wr(st_r);
      end
    endcase
    if (sync_reset)
      st_nxt = idle_clear();
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r.state  <= cap_pkg::CAP_IDLE;
      st_r.rdata  <= `CAP_READDATA_RST;
      st_r.rvalid <= 1'b0;
      st_r.tout   <= 1'b0;
      st_r.done   <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stall until the answer cycle; drops with readdata_valid
  assign status_waitrequest    = stall_level(busy, st_r.done,
                                             status_read, status_write);
  assign status_readdata       = st_r.rdata;
  assign status_readdata_valid = st_r.rvalid;
  assign status_read_timeout   = st_r.tout;
endmodule // cap_csr_port
`default_nettype wire

// ---- test/cap_properties.sv ----
`include "cap_params.svh"
`default_nettype none
module cap_properties
(
  input wire logic        clk, rst_b, sync_reset, status_read, reg_ack, reg_rd,
  input wire logic        status_readdata_valid, status_waitrequest, status_read_timeout,
  input wire logic [15:0] status_addr, reg_addr,
  input wire logic [31:0] status_readdata, reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence ack_s; reg_ack && reg_rd && !sync_reset; endsequence
  a_read_data: assert property (ack_s |=> status_readdata_valid &&
    status_readdata == $past(reg_rdata)) else $error("bad data");
  a_addr_pass: assert property (status_read && status_waitrequest && !sync_reset |->
    reg_rd && reg_addr == status_addr) else $error("bad addr");
  a_stall_hold: assert property (status_read && !status_readdata_valid |->
    status_waitrequest) else $error("no stall");
  a_stall_drop: assert property (status_readdata_valid |-> !status_waitrequest)
    else $error("stall held");
  a_flag_data: assert property (status_read_timeout |-> status_readdata_valid &&
    status_readdata == `CAP_TIMEOUT_DATA) else $error("bad flag");
  a_no_hang: assert property ($rose(status_read) |-> ##[1:131] !status_waitrequest)
    else $error("hang");
  a_reset_idle: assert property (sync_reset |=> !status_readdata_valid &&
    !status_read_timeout) else $error("not idle");
  a_one_pulse: assert property (status_readdata_valid |=> !status_readdata_valid)
    else $error("long pulse");
endmodule // cap_properties
bind cap_csr_port cap_properties cap_properties_inst (.*);
`default_nettype wire

// ---- test/cap_fabric_model.sv ----
`default_nettype none
module cap_fabric_model
(
  input wire logic        clk, reg_rd, reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [7:0]  lat,
  output logic [31:0]     reg_rdata = 32'h0,
  output logic            reg_ack = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [16];
  logic [7:0]  cnt = 8'h00;
  wire         hit = (reg_rd | reg_wr) && !reg_ack && cnt == lat;
  always @(posedge clk)
  begin
    reg_ack <= hit;
    reg_rdata <= hit ? mem[reg_addr[3:0]] : ~reg_rdata;
    cnt <= (reg_rd | reg_wr) && !reg_ack ? cnt + 8'h01 : 8'h00;
    if (hit && !reg_rd)
      mem[reg_addr[3:0]] <= reg_wdata;
  end
endmodule // cap_fabric_model
`default_nettype wire

// ---- test/cap_csr_port_tb_top.sv ----
`include "cap_params.svh"
`default_nettype none
module cap_csr_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic [59:0] rows [4] = '{60'h1_0003_12345678_00, 60'h1_0004_a5a50f0f_05,
    60'h0_0003_12345678_03, 60'h0_0004_a5a50f0f_28};
  logic clk = 1'h0, rst_b = 1'h0, sync_reset = 1'h0, status_read = 1'h0, status_write = 1'h0;
  logic status_readdata_valid, status_waitrequest, status_read_timeout, reg_rd, reg_wr;
  logic reg_ack, cv, ct;
  logic [15:0] status_addr = 16'h0, reg_addr;
  logic [31:0] status_writedata = 32'h0, status_readdata, reg_wdata, reg_rdata, cq;
  logic [7:0] lat = 8'h00;
  int n_errors = 0, checks_done = 0, cyc = 0, cn;
  cap_csr_port cap_csr_port_inst (.clk, .rst_b, .sync_reset, .status_addr, .status_read,
    .status_write, .status_writedata, .status_readdata, .status_readdata_valid,
    .status_waitrequest, .status_read_timeout, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_ack);
  cap_fabric_model cap_fabric_model_inst (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .lat, .reg_rdata, .reg_ack);
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'h1)
    begin
      n_errors++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task automatic xfer(input logic [59:0] r);
    @(posedge clk);
    {status_addr, status_writedata, lat} <= r[55:0];
    {status_write, status_read} <= {r[56], !r[56]};
    cn = 0;
    do
    begin
      @(negedge clk);
      cn++;
    end while (status_waitrequest !== 1'h0 && cn < 300);
    {cq, cv, ct} = {status_readdata, status_readdata_valid, status_read_timeout};
    @(posedge clk);
    {status_write, status_read} <= 2'h0;
  endtask
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    @(negedge clk);
    chk(status_readdata === 32'h0 && status_readdata_valid === 1'h0);
    @(posedge clk);
    foreach (rows[i])
    begin
      xfer(rows[i]);
      chk(cv === !rows[i][56] && (rows[i][56] || cq === rows[i][39:8]) && !ct);
    end
    xfer(60'h0_00ff_00000000_ff);
    chk(ct && cv && cq === `CAP_TIMEOUT_DATA && cn <= `CAP_TIMEOUT_CYC + 3
      && cn >= `CAP_TIMEOUT_CYC);
    repeat (5) @(posedge clk);
    {status_addr, lat} <= {16'h0004, 8'hff};
    status_read <= 1'h1;
    repeat (5) @(posedge clk);
    {sync_reset, status_read} <= 2'h2;
    @(posedge clk);
    sync_reset <= 1'h0;
    @(negedge clk);
    chk({status_readdata_valid, status_read_timeout, status_waitrequest} === 3'h0
      && status_readdata === `CAP_READDATA_RST);
    close_out();
  end
endmodule // cap_csr_port_tb_top
`default_nettype wire
